/* File: rtl/clockgen_wd_regs.vh */
// Register offsets, field positions, reset values and timing for the watchdog slice
`ifndef CLOCKGEN_WD_REGS_VH
`define CLOCKGEN_WD_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte index on the serial register port)
// ----------------------------------------------------------------------------
`define GRP66_EN_OFFS        8'h04
`define WD_CTRL_OFFS         8'h05
`define WD_PERIOD_OFFS       8'h06
`define DIV_MNH_OFFS         8'h07
`define DIV_NL_OFFS          8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WD_CTRL_STRAP_BIT    7
`define WD_CTRL_RUN_BIT      6
`define WD_CTRL_EXP_BIT      5
`define WD_CTRL_SAFE_HI      4
`define WD_CTRL_SAFE_LO      0
`define DIV_NH_BIT           7
`define DIV_FB_B_BIT         6
`define DIV_FB_A_BIT         5
`define DIV_M_HI             4
`define DIV_M_LO             0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GRP66_EN_RST         8'hff
`define WD_SAFE_RST          5'h00
`define WD_PERIOD_RST        8'h08
`define DIV_NH_RST           1'h1
`define DIV_FB_B_RST         1'h1
`define DIV_FB_A_RST         1'h0
`define DIV_M_RST            5'h0d
`define DIV_NL_RST           8'h67
`define RDATA_UNMAPPED       8'h00

// ----------------------------------------------------------------------------
// Timing: one watchdog count is 250 ms; clock is 100 MHz (100000 kHz)
// ----------------------------------------------------------------------------
`define WD_STEP_MS           250
`define CLK_KHZ              100000
`define WD_STEP_CYCLES       (`WD_STEP_MS * `CLK_KHZ)

`endif

/* File: rtl/wd_step_timer.v */
// Free-running step timer that pulses once per watchdog count interval
`timescale 1ns/1ps
`include "clockgen_wd_regs.vh"

module wd_step_timer #(
    parameter integer STEP_CYCLES = `WD_STEP_CYCLES,
    parameter integer CNT_W       = 25
) (
    input  wire clock_i,
    input  wire rst_i,
    input  wire restart_i,
    output reg  step_o
);

    reg [CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------

    // Restart realigns so the first step after a start is a full interval
    always @(posedge clock_i) begin
        if (rst_i || restart_i) begin
            cnt_r  <= {CNT_W{1'b0}};
            step_o <= 1'b0;
        end else if (cnt_r == STEP_CYCLES[CNT_W-1:0] - 1'b1) begin
            cnt_r  <= {CNT_W{1'b0}};
            step_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            step_o <= 1'b0;
        end
    end

endmodule // wd_step_timer

/* File: rtl/clockgen_watchdog_divisor_regs.v */
// Output-group enables, watchdog and M/N divisor registers of the clock generator
//
// Function
// RULE1: Low four group bits gate mid-rate outputs.
// RULE2: Upper group bits reserved, reset one.
// RULE3: Control bit 7 reads captured strap.
// RULE4: Writing run bit starts or stops watchdog.
// RULE5: Run bit reads back counting state.
// RULE6: Countdown reaching zero sets expired flag.
// RULE7: Expired flag ignores host writes.
// RULE8: Timeout with reload loads fallback code.
// RULE9: Period register eight bits, 250 ms steps.
// RULE10: Period resets to eight, two seconds.
// RULE11: Running period decrements each step.
// RULE12: Period read returns remaining count.
// RULE13: N bit 8 in divisor register bit 7.
// RULE14: Low divisor register holds N bits 7..0.
// RULE15: M is five bits, reset 01101.
// RULE16: Host keeps factory bits at reset values.
// RULE17: Timeout without reload uses latched pins.
// RULE18: Timeout clears divisor synthesis enable.
// RULE19: Synth frequency is reference times (N+4)/M.
// RULE20: Restarting watchdog clears the expired flag.
`timescale 1ns/1ps
`include "clockgen_wd_regs.vh"

module clockgen_watchdog_divisor_regs #(
    parameter integer STEP_CYCLES = `WD_STEP_CYCLES,
    parameter integer STEP_CNT_W  = 25
) (
    input  wire       clock_i,
    input  wire       rst_i,
    // Register port, fed by the serial host decoder
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg_rvalid_o,
    // Straps and neighbouring control
    input  wire       drive_select_strap_b_i,
    input  wire [4:0] latched_freq_code_i,
    input  wire       fallback_reload_en_i,
    input  wire       divisor_synth_enable_i,
    // Outputs to the clock unit
    output reg  [3:0] mid_rate_clock_group_en_o,
    output reg        freq_reload_o,
    output reg  [4:0] freq_select_code_o,
    output reg        divisor_synth_clear_o,
    output reg        divisor_synth_active_o,
    output reg  [4:0] synth_m_o,
    output reg  [9:0] synth_n_plus4_o,
    output reg        factory_bit_b_o,
    output reg        factory_bit_a_o,
    output reg        watchdog_run_o,
    output reg        watchdog_expired_flag_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------

    reg  [7:0] grp66_en_r;
    reg        strap_b_r;
    reg        strap_taken_r;
    reg        watchdog_run_r;
    reg        watchdog_run_nxt;
    reg        watchdog_expired_flag_r;
    reg        watchdog_expired_flag_nxt;
    reg  [4:0] fallback_freq_code_r;
    reg  [7:0] watchdog_period_count_r;
    reg  [7:0] watchdog_period_count_nxt;
    reg        div_nh_r;
    reg        factory_bit_b_r;
    reg        factory_bit_a_r;
    reg  [4:0] div_m_r;
    reg  [7:0] div_nl_r;
    reg  [7:0] rdata_nxt;
    reg        timeout_nxt;

    wire       step;
    wire       wr_grp;
    wire       wr_ctrl;
    wire       wr_period;
    wire       wr_mnh;
    wire       wr_nl;
    wire       start_req;
    wire       stop_req;
    wire [8:0] n_div;

    // Group reset kept at full width so the four-bit mirror takes a slice
    localparam [7:0] GRP66_RST_VAL = `GRP66_EN_RST;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // Write strobes per register; unknown offsets are ignored
    assign wr_grp    = reg_wr_i && (reg_addr_i == `GRP66_EN_OFFS);
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == `WD_CTRL_OFFS);
    assign wr_period = reg_wr_i && (reg_addr_i == `WD_PERIOD_OFFS);
    assign wr_mnh    = reg_wr_i && (reg_addr_i == `DIV_MNH_OFFS);
    assign wr_nl     = reg_wr_i && (reg_addr_i == `DIV_NL_OFFS);

    // RULE4: run bit write
    assign start_req = wr_ctrl && reg_wdata_i[`WD_CTRL_RUN_BIT];
    assign stop_req  = wr_ctrl && !reg_wdata_i[`WD_CTRL_RUN_BIT];

    // RULE13: nine-bit N assembly
    assign n_div     = {div_nh_r, div_nl_r};

    // ------------------------------------------------------------------------
    // Step timer
    // ------------------------------------------------------------------------

    // RULE9: 250 ms step source
    wd_step_timer #(
        .STEP_CYCLES (STEP_CYCLES),
        .CNT_W       (STEP_CNT_W)
    ) u_step (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .restart_i (start_req),
        .step_o    (step)
    );

    // ------------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------------

    // RULE3: capture strap once after reset release
    // Taken by the clock, never by the reset, so the strap level is sampled
    always @(posedge clock_i) begin
        if (rst_i) begin
            strap_taken_r <= 1'b0;
            strap_b_r     <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            strap_b_r     <= drive_select_strap_b_i;
        end
    end

    // ------------------------------------------------------------------------
    // Output group enables
    // ------------------------------------------------------------------------

    // RULE1: enable bits, all running after reset
    // RULE2: reserved bits kept writable, reset to one
    always @(posedge clock_i) begin
        if (rst_i) begin
            grp66_en_r <= `GRP66_EN_RST;
        end else if (wr_grp) begin
            grp66_en_r <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog next state
    // ------------------------------------------------------------------------

    // Countdown, expiry and host control in one place
    always @* begin
        watchdog_run_nxt          = watchdog_run_r;
        watchdog_expired_flag_nxt = watchdog_expired_flag_r;
        watchdog_period_count_nxt = watchdog_period_count_r;
        timeout_nxt               = 1'b0;

        // RULE9: host loads the period
        if (wr_period) begin
            watchdog_period_count_nxt = reg_wdata_i;
        end

        // RULE20: restart clears the expired flag
        if (start_req) begin
            watchdog_run_nxt          = 1'b1;
            watchdog_expired_flag_nxt = 1'b0;
        end else if (stop_req) begin
            watchdog_run_nxt = 1'b0;
        end

        // RULE11: decrement once per step while running
        // A period write in the same cycle wins over the decrement
        if (watchdog_run_r && step && !start_req && !stop_req) begin
            if (watchdog_period_count_r <= 8'h01) begin
                // RULE6: reaching zero sets the expired flag
                if (!wr_period) begin
                    watchdog_period_count_nxt = 8'h00;
                end
                watchdog_run_nxt          = 1'b0;
                watchdog_expired_flag_nxt = 1'b1;
                timeout_nxt               = 1'b1;
            end else if (!wr_period) begin
                watchdog_period_count_nxt = watchdog_period_count_r - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog registers
    // ------------------------------------------------------------------------

    // RULE10: period resets to eight steps
    // RULE7: written flag bit ignored; set by expiry, cleared only by a run-bit start write
    always @(posedge clock_i) begin
        if (rst_i) begin
            watchdog_run_r          <= 1'b0;
            watchdog_expired_flag_r <= 1'b0;
            watchdog_period_count_r <= `WD_PERIOD_RST;
            fallback_freq_code_r    <= `WD_SAFE_RST;
        end else begin
            watchdog_run_r          <= watchdog_run_nxt;
            watchdog_expired_flag_r <= watchdog_expired_flag_nxt;
            watchdog_period_count_r <= watchdog_period_count_nxt;
            if (wr_ctrl) begin
                fallback_freq_code_r <= reg_wdata_i[`WD_CTRL_SAFE_HI:`WD_CTRL_SAFE_LO];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timeout actions
    // ------------------------------------------------------------------------

    // One-cycle reload and clear pulses toward the select logic
    always @(posedge clock_i) begin
        if (rst_i) begin
            freq_reload_o         <= 1'b0;
            freq_select_code_o    <= 5'h00;
            divisor_synth_clear_o <= 1'b0;
        end else begin
            freq_reload_o         <= timeout_nxt;
            // RULE18: expiry drops divisor synthesis
            divisor_synth_clear_o <= timeout_nxt;
            if (timeout_nxt) begin
                // RULE8: fallback code when reload enabled
                // RULE17: otherwise the latched pin code
                if (fallback_reload_en_i) begin
                    freq_select_code_o <= fallback_freq_code_r;
                end else begin
                    freq_select_code_o <= latched_freq_code_i;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Divisor registers
    // ------------------------------------------------------------------------

    // RULE13: N bit 8 shares the register with M
    // RULE15: M in the low five bits
    // RULE16: factory bits stored as written; host is expected to keep them
    always @(posedge clock_i) begin
        if (rst_i) begin
            div_nh_r        <= `DIV_NH_RST;
            factory_bit_b_r <= `DIV_FB_B_RST;
            factory_bit_a_r <= `DIV_FB_A_RST;
            div_m_r         <= `DIV_M_RST;
        end else if (wr_mnh) begin
            div_nh_r        <= reg_wdata_i[`DIV_NH_BIT];
            factory_bit_b_r <= reg_wdata_i[`DIV_FB_B_BIT];
            factory_bit_a_r <= reg_wdata_i[`DIV_FB_A_BIT];
            div_m_r         <= reg_wdata_i[`DIV_M_HI:`DIV_M_LO];
        end
    end

    // RULE14: low eight bits of N
    always @(posedge clock_i) begin
        if (rst_i) begin
            div_nl_r <= `DIV_NL_RST;
        end else if (wr_nl) begin
            div_nl_r <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Synthesizer terms
    // ------------------------------------------------------------------------

    // RULE19: hand over M and N+4 so the PLL forms ref*(N+4)/M
    // Active only while the neighbouring enable is set and not being cleared
    always @(posedge clock_i) begin
        if (rst_i) begin
            synth_m_o              <= `DIV_M_RST;
            synth_n_plus4_o        <= {1'b0, `DIV_NH_RST, `DIV_NL_RST} + 10'h004;
            divisor_synth_active_o <= 1'b0;
        end else begin
            synth_m_o              <= div_m_r;
            synth_n_plus4_o        <= {1'b0, n_div} + 10'h004;
            // RULE18: no synthesis in the timeout cycle
            divisor_synth_active_o <= divisor_synth_enable_i && !timeout_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------

    // Read mux; unmapped offsets return zero
    always @* begin
        case (reg_addr_i)
            `GRP66_EN_OFFS: begin
                rdata_nxt = grp66_en_r;
            end
            `WD_CTRL_OFFS: begin
                // RULE3: strap readback; RULE5: live counting state
                rdata_nxt = {strap_b_r, watchdog_run_r, watchdog_expired_flag_r,
                             fallback_freq_code_r};
            end
            `WD_PERIOD_OFFS: begin
                // RULE12: remaining count, not the written value
                rdata_nxt = watchdog_period_count_r;
            end
            `DIV_MNH_OFFS: begin
                rdata_nxt = {div_nh_r, factory_bit_b_r, factory_bit_a_r, div_m_r};
            end
            `DIV_NL_OFFS: begin
                rdata_nxt = div_nl_r;
            end
            default: begin
                rdata_nxt = `RDATA_UNMAPPED;
            end
        endcase
    end

    // Read data registered, valid one cycle after the strobe
    always @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------------------

    // Mirrors of internal state; one cycle behind the state itself
    always @(posedge clock_i) begin
        if (rst_i) begin
            mid_rate_clock_group_en_o <= GRP66_RST_VAL[3:0];
            factory_bit_b_o           <= `DIV_FB_B_RST;
            factory_bit_a_o           <= `DIV_FB_A_RST;
            watchdog_run_o            <= 1'b0;
            watchdog_expired_flag_o   <= 1'b0;
        end else begin
            // RULE1: gate for the four mid-rate outputs
            mid_rate_clock_group_en_o <= grp66_en_r[3:0];
            factory_bit_b_o           <= factory_bit_b_r;
            factory_bit_a_o           <= factory_bit_a_r;
            watchdog_run_o            <= watchdog_run_r;
            watchdog_expired_flag_o   <= watchdog_expired_flag_r;
        end
    end

endmodule // clockgen_watchdog_divisor_regs

/* File: dv/host_model.sv */
// Register-port host model standing in for the serial host controller
`timescale 1ns/1ps

module host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    // Released lines carry inverted data so stale values never pass
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'hff;
        wdata_o = 8'hff;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // One-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clock_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // Read strobe, then a bounded wait for the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic got;
        got = 1'b0;
        d = 8'hxx;
        @(negedge clock_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clock_i);
        rd_o = 1'b0;
        addr_o = ~a;
        repeat (3) begin
            if (!got && rvalid_i === 1'b1) begin
                d = rdata_i;
                got = 1'b1;
            end
            if (!got) @(negedge clock_i);
        end
    endtask

    task automatic wr_div(input logic n8, input logic [4:0] m);
        wr(8'h07, {n8, 1'b1, 1'b0, m});
    endtask
endmodule // host_model

/* File: dv/regs_chk.sv */
// Port-level assertions for the watchdog and divisor register slice
`timescale 1ns/1ps

module regs_chk #(
    parameter integer STEP_CYCLES = 8
) (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rvalid_o,
    input wire logic [4:0] latched_freq_code_i,
    input wire logic       fallback_reload_en_i,
    input wire logic [3:0] mid_rate_clock_group_en_o,
    input wire logic       freq_reload_o,
    input wire logic [4:0] freq_select_code_o,
    input wire logic       divisor_synth_clear_o,
    input wire logic       watchdog_run_o,
    input wire logic       watchdog_expired_flag_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // Control writes decoded once; safe code shadowed for reload checks
    wire       ctl_wr = reg_wr_i && reg_addr_i == 8'h05;
    wire       start_wr = ctl_wr && reg_wdata_i[6];
    logic [4:0] safe_r;
    always @(posedge clock_i) begin
        if (rst_i) safe_r <= 5'h00;
        else if (ctl_wr) safe_r <= reg_wdata_i[4:0];
    end

    sequence s_start;
        start_wr;
    endsequence
    sequence s_stop;
        ctl_wr && !reg_wdata_i[6];
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_read_gives_valid: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe not answered");
    a_valid_only_read: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without read");
    a_group_en_follows: assert property (reg_wr_i && reg_addr_i == 8'h04 |->
        ##2 mid_rate_clock_group_en_o == $past(reg_wdata_i[3:0], 2))
        else $error("group enables differ from write");
    a_run_after_start: assert property (s_start |-> ##2 watchdog_run_o)
        else $error("watchdog not running after start");
    a_stop_halts_run: assert property (s_stop |-> ##2 !watchdog_run_o)
        else $error("watchdog still running after stop");
    a_reload_pairs_clear: assert property (freq_reload_o == divisor_synth_clear_o)
        else $error("reload and synth clear not paired");
    // Flag mirror rises one cycle after the reload pulse has been shown
    a_expiry_reloads: assert property ($rose(watchdog_expired_flag_o) |->
        !watchdog_run_o && $past(freq_reload_o))
        else $error("expiry without reload");
    a_reload_code: assert property (freq_reload_o |-> freq_select_code_o ==
        (fallback_reload_en_i ? safe_r : latched_freq_code_i))
        else $error("wrong reload code");
    a_expired_clears: assert property ($fell(watchdog_expired_flag_o) |->
        $past(start_wr, 2))
        else $error("expired flag cleared without start");
endmodule // regs_chk

bind clockgen_watchdog_divisor_regs regs_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (
    .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
    .latched_freq_code_i(latched_freq_code_i), .fallback_reload_en_i(fallback_reload_en_i),
    .mid_rate_clock_group_en_o(mid_rate_clock_group_en_o), .freq_reload_o(freq_reload_o),
    .freq_select_code_o(freq_select_code_o), .divisor_synth_clear_o(divisor_synth_clear_o),
    .watchdog_run_o(watchdog_run_o), .watchdog_expired_flag_o(watchdog_expired_flag_o));

/* File: dv/tb_top.sv */
// Self-checking bench for the watchdog and divisor register slice
`timescale 1ns/1ps

module tb_top;
    logic       clock_i, rst_i, wr, rd, rvalid, strap, fb_en, synth_en;
    logic [7:0] addr, wdata, rdata, d;
    logic [4:0] latched, code, m;
    logic [3:0] grp;
    logic       reload, clr, active, fb_b, fb_a, run, expd;
    logic [9:0] n4;
    int         fails, n_tests, cycles;
    logic [7:0] ra [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h03, 8'h09};
    logic [7:0] re [7] = '{8'hff, 8'h80, 8'h08, 8'hcd, 8'h67, 8'h00, 8'h00};

    // ------------------------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------------------------
    // Short step so timeouts take tens of cycles, not millions
    clockgen_watchdog_divisor_regs #(.STEP_CYCLES(8), .STEP_CNT_W(25)) uut (
        .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .drive_select_strap_b_i(strap),
        .latched_freq_code_i(latched), .fallback_reload_en_i(fb_en),
        .divisor_synth_enable_i(synth_en), .mid_rate_clock_group_en_o(grp),
        .freq_reload_o(reload), .freq_select_code_o(code), .divisor_synth_clear_o(clr),
        .divisor_synth_active_o(active), .synth_m_o(m), .synth_n_plus4_o(n4),
        .factory_bit_b_o(fb_b), .factory_bit_a_o(fb_a), .watchdog_run_o(run),
        .watchdog_expired_flag_o(expd));
    host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Hang guard: the whole run needs about 120 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        check(d, e);
    endtask

    // Bounded wait for the timeout reload pulse, then its side effects
    task automatic wait_reload(input logic [4:0] e);
        int k;
        k = 0;
        while (reload !== 1'b1 && k < 60) begin
            @(negedge clock_i);
            k++;
        end
        check(reload, 1'b1);
        check(code, e);
        check(clr, 1'b1);
        // Outside divisor enable register obeys the clear pulse
        synth_en = 1'b0;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        strap = 1'b1;
        latched = 5'h15;
        fb_en = 1'b1;
        synth_en = 1'b1;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        // Reset values, strap readback and unmapped reads
        for (int i = 0; i < 7; i++) rd_chk(ra[i], re[i]);
        check(grp, 4'hf);
        check({fb_b, fb_a, m}, 7'h4d);
        check(n4, 10'h16b);
        // Group enables and reserved storage
        host.wr(8'h04, 8'h5a);
        rd_chk(8'h04, 8'h5a);
        check(grp, 4'ha);
        // Strap and expired bits ignore writes; safe code stored
        host.wr(8'h05, 8'h2a);
        rd_chk(8'h05, 8'h8a);
        // Divisor programming
        host.wr_div(1'b0, 5'h11);
        host.wr(8'h08, 8'h2c);
        rd_chk(8'h07, 8'h51);
        rd_chk(8'h08, 8'h2c);
        check({fb_b, fb_a, m}, 7'h51);
        check(n4, 10'h030);
        check(active, 1'b1);
        // Timeout with safe reload
        host.wr(8'h06, 8'h03);
        host.wr(8'h05, 8'h4a);
        rd_chk(8'h05, 8'hca);
        repeat (8) @(negedge clock_i);
        rd_chk(8'h06, 8'h02);
        wait_reload(5'h0a);
        repeat (2) @(negedge clock_i);
        check(active, 1'b0);
        rd_chk(8'h05, 8'haa);
        rd_chk(8'h06, 8'h00);
        host.wr(8'h05, 8'h0a);
        rd_chk(8'h05, 8'haa);
        // Restart clears flag; zero count reloads latched pins
        fb_en = 1'b0;
        host.wr(8'h06, 8'h00);
        host.wr(8'h05, 8'h4a);
        rd_chk(8'h05, 8'hca);
        wait_reload(5'h15);
        // Stop before the first step: no expiry, count kept
        host.wr(8'h06, 8'h02);
        host.wr(8'h05, 8'h4a);
        host.wr(8'h05, 8'h0a);
        repeat (30) @(negedge clock_i);
        rd_chk(8'h05, 8'h8a);
        rd_chk(8'h06, 8'h02);
        stop_test();
    end
endmodule // tb_top
